// *** rtl/pdk_cfg.svh ***
// Constants of the program and debug port access logic
`ifndef PDK_CFG_SVH
`define PDK_CFG_SVH
// Instruction classes, taken from bits 7:5 of the opcode byte
`define PDK_OP_LD 3'h1
`define PDK_OP_STS 3'h2
`define PDK_OP_STPTR 3'h3
`define PDK_OP_LDCS 3'h4
`define PDK_OP_RPT 3'h5
`define PDK_OP_STCS 3'h6
`define PDK_OP_KEY 3'h7
// Opcode option bits
`define PDK_BIT_WIDE 0
`define PDK_BIT_PTRRD 1
`define PDK_BIT_INC 2
// Answer bytes
`define PDK_ACK 8'h40
`define PDK_NACK 8'h00
// Activation keys, least significant byte sent first
`define PDK_KEY_ERASE 64'h4E564D4572617365
`define PDK_KEY_PROG 64'h4E564D50726F6720
`define PDK_KEY_LAST 4'h7
// Control space offsets and fields
`define PDK_CS_KEY 4'h7
`define PDK_CS_RST 4'h8
`define PDK_CS_SYS 4'hB
`define PDK_KS_ERASE 3
`define PDK_KS_PROG 4
`define PDK_SS_LOCK 0
`define PDK_SS_PROG 3
`define PDK_RST_SIG 8'h59
`define PDK_RST_CLR 8'h00
// Brown-out detector active field
`define PDK_BOD_ON 2'h1
`define PDK_BOD_OFF 2'h0
`endif

// *** rtl/pdk_fifo.sv ***
// Answer FIFO with valid and ready on both sides
`timescale 1ns/1ps
module pdk_fifo #(
   parameter int W = 8,
   parameter int D = 16
) (
   input wire logic clock,
   input wire logic reset,
   input wire logic ce,
   input wire logic [W-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [W-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic ov;
      logic ir;
   } pdk_fifo_st_t;
   pdk_fifo_st_t s_r, s_nxt;
   logic in_fire, out_fire;
   assign in_fire = in_valid & s_r.ir & ce;
   assign out_fire = out_ready & s_r.ov & ce;
   assign in_ready = s_r.ir;
   assign out_valid = s_r.ov;
   assign out_data = s_r.mem[s_r.rp];
   // Pointer and count update; flags are registered from the next count
   always_comb begin
      s_nxt = s_r;
      if (in_fire) begin
         s_nxt.mem[s_r.wp] = in_data;
         s_nxt.wp = s_r.wp + 1'b1;
      end
      if (out_fire)
         s_nxt.rp = s_r.rp + 1'b1;
      s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, in_fire} - {{AW{1'b0}}, out_fire};
      s_nxt.ov = s_nxt.cnt != '0;
      s_nxt.ir = s_nxt.cnt != (AW+1)'(D);
   end
   // State register
   always_ff @(posedge clock) begin
      if (reset) begin
         s_r <= '0;
         s_r.ir <= 1'b1;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end
endmodule : pdk_fifo

// *** rtl/pdk_pkg.sv ***
// Types of the program and debug port access logic
package pdk_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_DATA, ST_STNEXT, ST_KEY, ST_CSDATA,
      ST_RPT, ST_LDGO, ST_LDNEXT, ST_BUS, ST_EMIT
   } pdk_state_t;
   typedef struct packed {
      pdk_state_t state;
      pdk_state_t ret;
      logic [7:0] op;
      logic [7:0] rpt;
      logic [7:0] out;
      logic [7:0] rst_reg;
      logic [3:0] cnt;
      logic [15:0] addr;
      logic [15:0] ptr;
      logic [63:0] key;
      logic key_erase;
      logic key_prog;
      logic sys_rst;
      logic init;
      logic locked;
      logic erasing;
      logic prog;
      logic erase_req;
      logic push;
      logic rx_rdy;
      logic bus_req;
      logic bus_we;
      logic [15:0] bus_addr;
      logic [7:0] bus_wdata;
      logic [1:0] bod_act;
      logic [2:0] bod_lvl;
   } pdk_st_t;
endpackage : pdk_pkg

// *** rtl/pdk_port.sv ***
// Program and debug port: instructions, keys, lock and erase control
//
// Functional notes
// - Acknowledge after store-direct address received
// - Store data bytes, acknowledge after writing
// - Indirect load reads bus at pointer
// - Optional pointer post-increment, works with repeat
// - Pointer readable; loads at most 16 bits
// - Recognise full-erase key, LSB first
// - Recognise programming key, LSB first
// - Set erase bit in key status
// - Reset held while signature stored
// - Lock flag reads zero when erase done
// - Erase clears lock, opens bus
// - Locked port reaches only control space
// - Brown-out forced on with fuse level
// - Set programming bit in key status
// - Programming flag set after reset pulse
`timescale 1ns/1ps
`include "pdk_cfg.svh"
module pdk_port (
   input wire logic clock,
   input wire logic reset,
   input wire logic ce,
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   output logic rx_ready,
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   output logic bus_req,
   output logic bus_we,
   output logic [15:0] bus_addr,
   output logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   input wire logic bus_ack,
   input wire logic lock_fuse,
   input wire logic [2:0] bod_fuse_level,
   input wire logic erase_done,
   output logic sys_reset_req,
   output logic erase_req,
   output logic [1:0] bod_active,
   output logic [2:0] bod_level,
   output logic prog_mode
);
   import pdk_pkg::*;
   pdk_pkg::pdk_st_t s_r, s_nxt;
   logic fire, f_rdy;

   // ==========================================================
   // Decoding helpers
   function automatic logic [3:0] op_bytes(input logic [7:0] op);
      op_bytes = op[`PDK_BIT_WIDE] ? 4'h2 : 4'h1;
   endfunction : op_bytes

   function automatic logic takes_byte(input pdk_state_t st);
      case (st)
         ST_IDLE, ST_ADDR, ST_DATA, ST_KEY, ST_CSDATA, ST_RPT:
            takes_byte = 1'b1;
         default:
            takes_byte = 1'b0;
      endcase
   endfunction : takes_byte

   function automatic logic [7:0] cs_read(input logic [3:0] a,
                                         input pdk_st_t s);
      cs_read = 8'h00;
      case (a)
         `PDK_CS_KEY: begin
            cs_read[`PDK_KS_ERASE] = s.key_erase;
            cs_read[`PDK_KS_PROG] = s.key_prog;
         end
         `PDK_CS_RST: cs_read = s.rst_reg;
         `PDK_CS_SYS: begin
            cs_read[`PDK_SS_LOCK] = s.locked | s.erasing;
            cs_read[`PDK_SS_PROG] = s.prog;
         end
         default: cs_read = 8'h00;
      endcase
   endfunction : cs_read

   // ==========================================================
   // Answer FIFO
   pdk_fifo #(.W(8), .D(16)) u_fifo (
      .clock(clock),
      .reset(reset),
      .ce(ce),
      .in_data(s_r.out),
      .in_valid(s_r.push),
      .in_ready(f_rdy),
      .out_data(tx_data),
      .out_valid(tx_valid),
      .out_ready(tx_ready)
   );

   assign fire = s_r.rx_rdy & rx_valid;
   assign rx_ready = s_r.rx_rdy;
   assign bus_req = s_r.bus_req;
   assign bus_we = s_r.bus_we;
   assign bus_addr = s_r.bus_addr;
   assign bus_wdata = s_r.bus_wdata;
   assign sys_reset_req = s_r.sys_rst;
   assign erase_req = s_r.erase_req;
   assign bod_active = s_r.bod_act;
   assign bod_level = s_r.bod_lvl;
   assign prog_mode = s_r.prog;

   // ==========================================================
   // Instruction sequencer
   always_comb begin
      s_nxt = s_r;
      s_nxt.erase_req = 1'b0;
      case (s_r.state)
         ST_IDLE: begin
            if (s_r.init) begin
               s_nxt.locked = lock_fuse;
               s_nxt.init = 1'b0;
            end else if (fire) begin
               s_nxt.op = rx_data;
               s_nxt.cnt = 4'h0;
               s_nxt.addr = {12'h000, rx_data[3:0]};
               case (rx_data[7:5])
                  `PDK_OP_STS, `PDK_OP_STPTR: s_nxt.state = ST_ADDR;
                  `PDK_OP_LD: s_nxt.state = ST_LDGO;
                  `PDK_OP_KEY: s_nxt.state = ST_KEY;
                  `PDK_OP_STCS: s_nxt.state = ST_CSDATA;
                  `PDK_OP_RPT: s_nxt.state = ST_RPT;
                  `PDK_OP_LDCS: begin
                     s_nxt.out = cs_read(rx_data[3:0], s_r);
                     s_nxt.push = 1'b1;
                     s_nxt.ret = ST_IDLE;
                     s_nxt.state = ST_EMIT;
                  end
                  default: s_nxt.state = ST_IDLE;
               endcase
            end
         end
         ST_ADDR: begin
            if (fire) begin
               s_nxt.cnt = s_r.cnt + 4'h1;
               if (s_r.cnt == 4'h0) begin
                  s_nxt.addr[7:0] = rx_data;
               end else begin
                  s_nxt.addr[15:8] = rx_data;
                  s_nxt.cnt = 4'h0;
                  if (s_r.op[7:5] == `PDK_OP_STPTR)
                     s_nxt.ptr = {rx_data, s_r.addr[7:0]};
                  s_nxt.out = `PDK_ACK;
                  s_nxt.push = 1'b1;
                  s_nxt.ret = (s_r.op[7:5] == `PDK_OP_STS) ? ST_DATA
                                                           : ST_IDLE;
                  s_nxt.state = ST_EMIT;
               end
            end
         end
         ST_DATA: begin
            if (fire) begin
               if (s_r.locked) begin
                  s_nxt.state = ST_STNEXT;
               end else begin
                  s_nxt.bus_req = 1'b1;
                  s_nxt.bus_we = 1'b1;
                  s_nxt.bus_addr = s_r.addr + {12'h000, s_r.cnt};
                  s_nxt.bus_wdata = rx_data;
                  s_nxt.state = ST_BUS;
               end
            end
         end
         ST_STNEXT: begin
            s_nxt.cnt = s_r.cnt + 4'h1;
            if (s_nxt.cnt == op_bytes(s_r.op)) begin
               s_nxt.out = s_r.locked ? `PDK_NACK : `PDK_ACK;
               s_nxt.push = 1'b1;
               s_nxt.ret = ST_IDLE;
               s_nxt.state = ST_EMIT;
            end else begin
               s_nxt.state = ST_DATA;
            end
         end
         ST_LDGO: begin
            if (s_r.op[`PDK_BIT_PTRRD]) begin
               s_nxt.out = (s_r.cnt == 4'h0) ? s_r.ptr[7:0]
                                             : s_r.ptr[15:8];
               s_nxt.push = 1'b1;
               s_nxt.ret = ST_LDNEXT;
               s_nxt.state = ST_EMIT;
            end else if (s_r.locked) begin
               s_nxt.out = 8'h00;
               s_nxt.push = 1'b1;
               s_nxt.ret = ST_LDNEXT;
               s_nxt.state = ST_EMIT;
            end else begin
               s_nxt.bus_req = 1'b1;
               s_nxt.bus_we = 1'b0;
               s_nxt.bus_addr = s_r.ptr + {12'h000, s_r.cnt};
               s_nxt.state = ST_BUS;
            end
         end
         ST_LDNEXT: begin
            s_nxt.cnt = s_r.cnt + 4'h1;
            s_nxt.state = ST_LDGO;
            if (s_nxt.cnt == op_bytes(s_r.op)) begin
               s_nxt.cnt = 4'h0;
               if (s_r.op[`PDK_BIT_INC] && !s_r.op[`PDK_BIT_PTRRD])
                  s_nxt.ptr = s_r.ptr + {12'h000, op_bytes(s_r.op)};
               if (s_r.rpt != 8'h00)
                  s_nxt.rpt = s_r.rpt - 8'h01;
               else
                  s_nxt.state = ST_IDLE;
            end
         end
         ST_BUS: begin
            if (bus_ack) begin
               s_nxt.bus_req = 1'b0;
               if (s_r.bus_we) begin
                  s_nxt.state = ST_STNEXT;
               end else begin
                  s_nxt.out = bus_rdata;
                  s_nxt.push = 1'b1;
                  s_nxt.ret = ST_LDNEXT;
                  s_nxt.state = ST_EMIT;
               end
            end
         end
         ST_EMIT: begin
            if (f_rdy) begin
               s_nxt.push = 1'b0;
               s_nxt.state = s_r.ret;
            end
         end
         ST_RPT: begin
            if (fire) begin
               s_nxt.rpt = rx_data;
               s_nxt.state = ST_IDLE;
            end
         end
         ST_KEY: begin
            if (fire) begin
               s_nxt.key = {rx_data, s_r.key[63:8]};
               s_nxt.cnt = s_r.cnt + 4'h1;
               if (s_r.cnt == `PDK_KEY_LAST) begin
                  s_nxt.cnt = 4'h0;
                  s_nxt.state = ST_IDLE;
                  if (s_nxt.key == `PDK_KEY_ERASE)
                     s_nxt.key_erase = 1'b1;
                  else if (s_nxt.key == `PDK_KEY_PROG)
                     s_nxt.key_prog = 1'b1;
               end
            end
         end
         ST_CSDATA: begin
            if (fire) begin
               s_nxt.state = ST_IDLE;
               if (s_r.addr[3:0] == `PDK_CS_RST) begin
                  s_nxt.rst_reg = rx_data;
                  s_nxt.sys_rst = rx_data == `PDK_RST_SIG;
                  if (s_r.sys_rst && !s_nxt.sys_rst) begin
                     if (s_r.key_erase) begin
                        s_nxt.key_erase = 1'b0;
                        s_nxt.erasing = 1'b1;
                        s_nxt.erase_req = 1'b1;
                        s_nxt.bod_act = `PDK_BOD_ON;
                        s_nxt.bod_lvl = bod_fuse_level;
                     end
                     if (s_r.key_prog) begin
                        s_nxt.key_prog = 1'b0;
                        s_nxt.prog = !s_r.locked;
                     end
                  end
               end
            end
         end
         default: s_nxt.state = ST_IDLE;
      endcase
      // Erase completion unlocks the port
      if (s_r.erasing && erase_done) begin
         s_nxt.erasing = 1'b0;
         s_nxt.locked = 1'b0;
         s_nxt.bod_act = `PDK_BOD_OFF;
      end
      s_nxt.rx_rdy = takes_byte(s_nxt.state) & ~s_nxt.init;
   end

   // State register, frozen while ce is low
   always_ff @(posedge clock) begin
      if (reset) begin
         s_r <= '0;
         s_r.init <= 1'b1;
         s_r.locked <= 1'b1;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   addr_ack_sent_a: assert property (
      ce && fire && s_r.state == ST_ADDR && s_r.cnt == 4'h1 &&
      s_r.op[7:5] == `PDK_OP_STS |=> s_r.push && s_r.out == `PDK_ACK)
      else $error("no acknowledge after store address");
   data_ack_sent_a: assert property (
      ce && s_r.state == ST_STNEXT && !s_r.locked &&
      s_r.cnt + 4'h1 == op_bytes(s_r.op)
      |=> s_r.push && s_r.out == `PDK_ACK)
      else $error("no acknowledge after store data");
   ld_ptr_addr_a: assert property (
      s_r.state == ST_BUS && !s_r.bus_we
      |-> s_r.bus_addr == s_r.ptr + {12'h000, s_r.cnt})
      else $error("load address differs from pointer");
   ptr_post_inc_a: assert property (
      ce && s_r.state == ST_LDNEXT && s_r.op[`PDK_BIT_INC] &&
      !s_r.op[`PDK_BIT_PTRRD] && s_r.cnt + 4'h1 == op_bytes(s_r.op)
      |=> s_r.ptr == $past(s_r.ptr) + {12'h000, op_bytes(s_r.op)})
      else $error("pointer not incremented");
   ptr_readback_a: assert property (
      ce && s_r.state == ST_LDGO && s_r.op[`PDK_BIT_PTRRD] &&
      s_r.cnt == 4'h0 |=> s_r.push && s_r.out == $past(s_r.ptr[7:0]))
      else $error("pointer low byte not returned");
   erase_key_a: assert property (
      ce && fire && s_r.state == ST_KEY && s_r.cnt == `PDK_KEY_LAST &&
      {rx_data, s_r.key[63:8]} == `PDK_KEY_ERASE |=> s_r.key_erase)
      else $error("erase key not accepted");
   prog_key_a: assert property (
      ce && fire && s_r.state == ST_KEY && s_r.cnt == `PDK_KEY_LAST &&
      {rx_data, s_r.key[63:8]} == `PDK_KEY_PROG |=> s_r.key_prog)
      else $error("programming key not accepted");
   bad_key_a: assert property (
      ce && fire && s_r.state == ST_KEY && s_r.cnt == `PDK_KEY_LAST &&
      {rx_data, s_r.key[63:8]} != `PDK_KEY_ERASE &&
      {rx_data, s_r.key[63:8]} != `PDK_KEY_PROG
      |=> $stable(s_r.key_erase) && $stable(s_r.key_prog))
      else $error("unknown key changed status");
   reset_hold_a: assert property (
      sys_reset_req == (s_r.rst_reg == `PDK_RST_SIG))
      else $error("reset request mismatch");
   locked_bus_a: assert property (
      s_r.locked |-> !bus_req)
      else $error("bus access while locked");
   erase_unlock_a: assert property (
      ce && s_r.erasing && erase_done |=> !s_r.locked && !s_r.erasing)
      else $error("erase did not unlock");
   bod_forced_a: assert property (
      s_r.erasing |-> bod_active == `PDK_BOD_ON)
      else $error("brown-out not forced during erase");
   prog_grant_a: assert property (
      $rose(prog_mode) |-> $past(s_r.key_prog) && $fell(sys_reset_req))
      else $error("programming flag without key and reset");

   erase_seen_c: cover property (s_r.erasing ##[1:1000] !s_r.locked);
   prog_seen_c: cover property ($rose(prog_mode));
   repeat_ld_c: cover property (s_r.state == ST_LDNEXT &&
                                s_r.rpt != 8'h00);
endmodule : pdk_port

// *** testbench/pdk_sys_model.sv ***
// System side model: bus memory and memory controller erase timing
`timescale 1ns/1ps
module pdk_sys_model (
   input wire logic clock,
   input wire logic reset,
   input wire logic slow,
   input wire logic bus_req,
   input wire logic bus_we,
   input wire logic [15:0] bus_addr,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   output logic bus_ack,
   input wire logic erase_req,
   output logic erase_done
);
   logic [7:0] mem [256];
   logic [1:0] dly;
   logic [4:0] ers;
   // Memory starts as the inverse of each low address byte
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = ~i[7:0];
      end
   end
   // One access at a time; slow mode adds three wait cycles
   always @(posedge clock) begin
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata; // Read data is only good with ack
      erase_done <= 1'b0;
      if (reset) begin
         dly <= 2'h0;
         ers <= 5'h00;
      end else begin
         if (bus_req && !bus_ack) begin
            if (dly == (slow ? 2'h3 : 2'h0)) begin
               bus_ack <= 1'b1;
               dly <= 2'h0;
               if (bus_we) begin
                  mem[bus_addr[7:0]] <= bus_wdata;
               end else begin
                  bus_rdata <= mem[bus_addr[7:0]];
               end
            end else begin
               dly <= dly + 2'h1;
            end
         end
         // Erase runs twenty cycles, then a one-cycle done pulse
         if (erase_req) begin
            ers <= 5'h14;
         end else if (ers != 5'h00) begin
            ers <= ers - 5'h01;
            erase_done <= (ers == 5'h01);
         end
      end
   end
endmodule : pdk_sys_model

// *** testbench/tb_pdk_port.sv ***
// Self-checking bench of the program and debug port
`timescale 1ns/1ps
`include "pdk_cfg.svh"
module tb_pdk_port;
   logic clock = 1'b0;
   logic reset, ce, rx_valid, tx_ready, slow, lock_fuse, req_q;
   logic rx_ready, tx_valid, bus_req, bus_we, bus_ack, erase_done;
   logic sys_reset_req, erase_req, prog_mode, s1, s2;
   logic [7:0] rx_data, tx_data, bus_rdata, bus_wdata, v, r1, r2;
   logic [15:0] bus_addr;
   logic [1:0] bod_active;
   logic [2:0] bod_level, bod_fuse_level;
   logic [7:0] got[$];
   int mismatches = 0;
   int n_tests = 0;
   int nbus = 0;
   int nerase = 0;
   int k;

   always #50 clock = ~clock;

   pdk_port i_dut (
      .clock(clock), .reset(reset), .ce(ce),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
      .lock_fuse(lock_fuse), .bod_fuse_level(bod_fuse_level),
      .erase_done(erase_done), .sys_reset_req(sys_reset_req),
      .erase_req(erase_req), .bod_active(bod_active),
      .bod_level(bod_level), .prog_mode(prog_mode)
   );

   pdk_sys_model i_mem (
      .clock(clock), .reset(reset), .slow(slow), .bus_req(bus_req),
      .bus_we(bus_we), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_rdata(bus_rdata), .bus_ack(bus_ack), .erase_req(erase_req),
      .erase_done(erase_done)
   );

   // Collect answer bytes, count bus accesses and erase starts
   always @(posedge clock) begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1 && ce === 1'b1) begin
         got.push_back(tx_data);
      end
      if (bus_req === 1'b1 && req_q !== 1'b1) begin
         nbus++;
      end
      if (erase_req === 1'b1) begin
         nerase++;
      end
      req_q <= bus_req;
   end

   // Compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen,
            exp);
      end
   endtask : check

   // Offer bytes in order, each held until the port takes it
   task automatic tx(input logic [7:0] q[$]);
      int n;
      @(posedge clock);
      foreach (q[i]) begin
         rx_data <= q[i];
         rx_valid <= 1'b1;
         n = 0;
         do begin
            @(posedge clock);
            n++;
         end while (rx_ready !== 1'b1 && n < 500);
      end
      rx_valid <= 1'b0;
   endtask : tx

   // Wait, bounded, for answer bytes
   task automatic wait_rx(input int n);
      int i;
      i = 0;
      while (got.size() < n && i < 400) begin
         @(posedge clock);
         i++;
      end
   endtask : wait_rx

   function automatic logic [7:0] pop();
      return (got.size() > 0) ? got.pop_front() : 8'hXX;
   endfunction : pop

   task automatic cs_rd(input logic [3:0] off);
      tx('{{`PDK_OP_LDCS, 1'b0, off}});
      wait_rx(1);
      v = pop();
   endtask : cs_rd

   // Store direct: address phase answer, then data phase answer
   task automatic sts(input logic [15:0] a, input logic [7:0] d[$],
      output logic [7:0] a1, output logic [7:0] a2);
      tx('{{`PDK_OP_STS, 4'h0, d.size() > 1}, a[7:0], a[15:8]});
      wait_rx(1);
      a1 = pop();
      tx(d);
      wait_rx(1);
      a2 = pop();
   endtask : sts

   task automatic set_ptr(input logic [15:0] p);
      tx('{8'h61, p[7:0], p[15:8]});
      wait_rx(1);
      v = pop();
   endtask : set_ptr

   // Key bytes go out least significant first
   task automatic key(input logic [63:0] kv);
      logic [7:0] q[$];
      q.push_back({`PDK_OP_KEY, 5'h00});
      for (int i = 0; i < 8; i++) begin
         q.push_back(kv[8*i +: 8]);
      end
      tx(q);
   endtask : key

   // Reset request: signature, then clear
   task automatic pulse(output logic a1, output logic a2);
      tx('{{`PDK_OP_STCS, 1'b0, `PDK_CS_RST}, `PDK_RST_SIG});
      repeat (3) @(posedge clock);
      a1 = sys_reset_req;
      tx('{{`PDK_OP_STCS, 1'b0, `PDK_CS_RST}, `PDK_RST_CLR});
      repeat (3) @(posedge clock);
      a2 = sys_reset_req;
   endtask : pulse

   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict

   // Cut a hang short well beyond the expected run length
   initial begin
      #(20000 * 100);
      mismatches++;
      give_verdict();
   end

   initial begin
      reset = 1'b1;
      ce = 1'b1;
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b1;
      slow = 1'b0;
      lock_fuse = 1'b1;
      bod_fuse_level = 3'h5;
      req_q = 1'b0;
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      // Locked: store refused, load gives zero, bus stays quiet
      k = nbus;
      sts(16'h1000, '{8'h11}, r1, r2);
      check(r1, `PDK_ACK);
      check(r2, `PDK_NACK);
      tx('{8'h20});
      wait_rx(1);
      check(pop(), 8'h00);
      check(nbus[15:0], k[15:0]);
      // User row key is not an activation key here
      key(64'h4E564D5573267465);
      cs_rd(`PDK_CS_KEY);
      check(v, 8'h00);
      key(`PDK_KEY_ERASE);
      cs_rd(`PDK_CS_KEY);
      check(v, 8'h01 << `PDK_KS_ERASE);
      // Full erase through a reset request pulse
      pulse(s1, s2);
      check(s1, 1'b1);
      check(s2, 1'b0);
      check(nerase[15:0], 16'h0001);
      check(bod_active, `PDK_BOD_ON);
      check(bod_level, 3'h5);
      cs_rd(`PDK_CS_SYS);
      check(v[`PDK_SS_LOCK], 1'b1);
      k = 0;
      do begin
         cs_rd(`PDK_CS_SYS);
         k++;
      end while (v[`PDK_SS_LOCK] !== 1'b0 && k < 30);
      check(v[`PDK_SS_LOCK], 1'b0);
      check(bod_active, `PDK_BOD_OFF);
      // Unlocked stores reach memory, one and two bytes
      k = nbus;
      sts(16'h1000, '{8'hA5}, r1, r2);
      check(r1, `PDK_ACK);
      check(r2, `PDK_ACK);
      check(i_mem.mem[0], 8'hA5);
      slow <= 1'b1;
      sts(16'h1002, '{8'h3C, 8'h5A}, r1, r2);
      check(r2, `PDK_ACK);
      check({i_mem.mem[3], i_mem.mem[2]}, 16'h5A3C);
      check(nbus[15:0] - k[15:0], 16'h0003);
      // Repeated incrementing load walks the addresses
      set_ptr(16'h1000);
      check(v, `PDK_ACK);
      tx('{8'hA0, 8'h02, 8'h24});
      wait_rx(3);
      check(pop(), 8'hA5);
      check(pop(), 8'hFE);
      check(pop(), 8'h3C);
      tx('{8'h23});
      wait_rx(2);
      check(pop(), 8'h03);
      check(pop(), 8'h10);
      set_ptr(16'h1002);
      tx('{8'h21});
      wait_rx(2);
      check(pop(), 8'h3C);
      check(pop(), 8'h5A);
      // Stall the drain past the FIFO depth, then empty it
      tx_ready <= 1'b0;
      tx('{8'h61, 8'h00, 8'h10, 8'hA0, 8'h13, 8'h20});
      repeat (300) @(posedge clock);
      check(got.size(), 16'h0000);
      check(tx_valid, 1'b1);
      // Clock enable low freezes the answer FIFO even when drained
      ce <= 1'b0;
      tx_ready <= 1'b1;
      repeat (5) @(posedge clock);
      check(got.size(), 16'h0000);
      check(tx_valid, 1'b1);
      ce <= 1'b1;
      wait_rx(21);
      check(pop(), `PDK_ACK);
      for (int i = 0; i < 20; i++) begin
         check(pop(), 8'hA5);
      end
      // Programming entry once unlocked
      slow <= 1'b0;
      key(`PDK_KEY_PROG);
      cs_rd(`PDK_CS_KEY);
      check(v, 8'h01 << `PDK_KS_PROG);
      pulse(s1, s2);
      check(s1, 1'b1);
      k = 0;
      do begin
         cs_rd(`PDK_CS_SYS);
         k++;
      end while (v[`PDK_SS_PROG] !== 1'b1 && k < 30);
      check(v[`PDK_SS_PROG], 1'b1);
      check(prog_mode, 1'b1);
      give_verdict();
   end
endmodule : tb_pdk_port
